// file: design/addr_pin_mux.sv
// Purpose: registered selection of address or port function on A8..A23, address drive on A0..A7
// Assumes: enable mask already decoded; released bus floats every pin in address function, port-function lines keep their drive
// Notes: upper lines left disabled fall back to their port function
`default_nettype none
module addr_pin_mux (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic released_i,
    input wire logic [ext_pin_pkg::UP_W-1:0] up_mask_i,
    input wire logic [ext_pin_pkg::LOW_W-1:0] low_dir_i,
    input wire logic [ext_pin_pkg::UP_W-1:0] port_out_i,
    input wire logic [ext_pin_pkg::UP_W-1:0] port_dir_i,
    input wire logic [ext_pin_pkg::ADDR_W-1:0] addr_i,
    output ext_pin_pkg::addr_pins_s pins_o
);
    import ext_pin_pkg::*;

    // =========================================================
    // pin selection
    addr_pins_s pins_ff;
    wire logic [UP_W-1:0] up_addr_oe;
    wire logic [LOW_W-1:0] low_addr_oe;
    wire logic [UP_W-1:0] up_val;
    wire logic [UP_W-1:0] up_oe;
    wire logic [ADDR_W-1:0] nxt_val;
    wire logic [ADDR_W-1:0] nxt_oe;

    // address drive stops while another master owns the bus
    assign up_addr_oe = released_i ? '0 : up_mask_i;
    assign low_addr_oe = released_i ? '0 : low_dir_i;
    // disabled upper lines carry the port value instead
    assign up_val = (addr_i[ADDR_W-1:UP_LSB] & up_mask_i) | (port_out_i & ~up_mask_i);
    assign up_oe = up_addr_oe | (port_dir_i & ~up_mask_i);
    assign nxt_val = {up_val, addr_i[LOW_W-1:0]};
    assign nxt_oe = {up_oe, low_addr_oe};

    // output register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pins_ff <= '0;
        end else begin
            pins_ff <= '{val: nxt_val, oe: nxt_oe};
        end
    end

    assign pins_o = pins_ff;
endmodule
`default_nettype wire

// file: design/ext_bus_pin_control.sv
// Purpose: external bus pin control with address enables and bus handshakes
// Assumes: internal bus signals synchronous to clk_sys_i; external handshake pins active low
// Notes: registers over AXI4-Lite; mode strap sampled during reset
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`default_nettype none
module ext_bus_pin_control (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // mode strap and internal bus side
    input wire logic rom_less_i,
    input wire logic [ext_pin_pkg::ADDR_W-1:0] int_addr_i,
    input wire logic ext_access_i,
    input wire logic three_state_i,
    input wire logic dram_lower_i,
    input wire logic int_ext_req_i,
    output logic wait_hold_o,
    // external pins
    input wire logic wait_n_i,
    input wire logic bus_release_request_in_n_i,
    output logic bus_grant_n_o,
    output logic released_bus_request_out_n_o,
    output logic lower_column_strobe_n_o,
    output ext_pin_pkg::addr_pins_s addr_pins_o
);
    import ext_pin_pkg::*;

    // =========================================================
    // registers
    logic [AE_W-1:0] ae_ff;
    logic [LOW_W-1:0] low_dir_ff;
    logic [CTL_W-1:0] ctl_ff;
    logic [UP_W-1:0] port_out_ff;
    logic [UP_W-1:0] port_dir_ff;
    bus_state_e state_ff;
    bus_state_e nxt_state;
    logic grant_n_ff;
    logic req_out_n_ff;
    logic strobe_n_ff;
    logic wait_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic awready_ff, wready_ff, arready_ff;

    // =========================================================
    // axi write path: address and data taken in either order
    wire logic aw_take = s_axi_awvalid && !aw_got_ff && !bvalid_ff;
    wire logic w_take = s_axi_wvalid && !w_got_ff && !bvalid_ff;
    wire logic do_write = aw_got_ff && w_got_ff && !bvalid_ff;
    wire logic [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                               {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wire logic wr_ctrl = do_write && aw_addr_ff == REG_ADDR_CTRL;
    wire logic wr_low = do_write && aw_addr_ff == REG_LOW_DIR;
    wire logic wr_pin = do_write && aw_addr_ff == REG_PIN_CTRL;
    wire logic wr_pout = do_write && aw_addr_ff == REG_PORT_OUT;
    wire logic wr_pdir = do_write && aw_addr_ff == REG_PORT_DIR;
    wire logic wr_hit = wr_ctrl || wr_low || wr_pin || wr_pout || wr_pdir
                        || aw_addr_ff == REG_STATUS;
    wire logic [31:0] wr_ae = ({28'h0000000, ae_ff} & ~wmask) | (w_data_ff & wmask);
    wire logic [31:0] wr_lo = ({24'h000000, low_dir_ff} & ~wmask) | (w_data_ff & wmask);
    wire logic [31:0] wr_ct = ({28'h0000000, ctl_ff} & ~wmask) | (w_data_ff & wmask);
    wire logic [31:0] wr_po = ({16'h0000, port_out_ff} & ~wmask) | (w_data_ff & wmask);
    wire logic [31:0] wr_pd = ({16'h0000, port_dir_ff} & ~wmask) | (w_data_ff & wmask);

    // write handshake and response
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= AXI_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end else begin
            awready_ff <= !do_write && !aw_got_ff && !aw_take && !(bvalid_ff && !s_axi_bready);
            wready_ff <= !do_write && !w_got_ff && !w_take && !(bvalid_ff && !s_axi_bready);
            if (aw_take) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_got_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? AXI_OKAY : AXI_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // software registers; the strap picks the address-enable reset value
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ae_ff <= rom_less_i ? AE_RST_ROMLESS : AE_RST_ROM;
            low_dir_ff <= '0;
            ctl_ff <= '0;
            port_out_ff <= '0;
            port_dir_ff <= '0;
        end else begin
            if (wr_ctrl) ae_ff <= wr_ae[AE_W-1:0];
            if (wr_low) low_dir_ff <= wr_lo[LOW_W-1:0];
            if (wr_pin) ctl_ff <= wr_ct[CTL_W-1:0];
            if (wr_pout) port_out_ff <= wr_po[UP_W-1:0];
            if (wr_pdir) port_dir_ff <= wr_pd[UP_W-1:0];
        end
    end

    // =========================================================
    // axi read path: one cycle from address to data
    wire logic ar_take = s_axi_arvalid && !rvalid_ff;
    wire logic [31:0] status_word = {28'h0000000, state_ff, 2'h0}
                                    | {30'h00000000, !req_out_n_ff, !grant_n_ff};
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            REG_ADDR_CTRL: rd_mux = {28'h0000000, ae_ff};
            REG_LOW_DIR: rd_mux = {24'h000000, low_dir_ff};
            REG_PIN_CTRL: rd_mux = {28'h0000000, ctl_ff};
            REG_PORT_OUT: rd_mux = {16'h0000, port_out_ff};
            REG_PORT_DIR: rd_mux = {16'h0000, port_dir_ff};
            REG_STATUS: rd_mux = status_word;
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // read response register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= AXI_OKAY;
            arready_ff <= 1'b1;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            arready_ff <= 1'b0;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // =========================================================
    // bus release state machine
    wire logic release_en = ctl_ff[CTL_RELEASE_EN];
    wire logic ext_req = release_en && !bus_release_request_in_n_i;
    wire logic released = state_ff == BUS_RELEASED;
    always_comb begin
        case (state_ff)
            BUS_OWNED: nxt_state = ext_req ? BUS_RELEASING : BUS_OWNED;
            // release completes only once the current external access ends
            BUS_RELEASING: nxt_state = !ext_req ? BUS_OWNED
                                     : (ext_access_i ? BUS_RELEASING : BUS_RELEASED);
            BUS_RELEASED: nxt_state = ext_req ? BUS_RELEASED : BUS_RECLAIM;
            BUS_RECLAIM: nxt_state = BUS_OWNED;
            default: nxt_state = BUS_OWNED;
        endcase
    end

    // handshake pins, all registered
    wire logic nxt_grant_n = nxt_state != BUS_RELEASED;
    wire logic nxt_req_out_n = !(nxt_state == BUS_RELEASED && int_ext_req_i
                                 && ctl_ff[CTL_REQ_OUT_EN]);
    wire logic nxt_strobe_n = !(ctl_ff[CTL_STROBE_EN] && ext_access_i
                                && dram_lower_i && !released);
    wire logic nxt_wait = ctl_ff[CTL_WAIT_EN] && !wait_n_i && ext_access_i
                          && three_state_i && !released;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_ff <= BUS_OWNED;
            grant_n_ff <= 1'b1;
            req_out_n_ff <= 1'b1;
            strobe_n_ff <= 1'b1;
            wait_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            grant_n_ff <= nxt_grant_n;
            req_out_n_ff <= nxt_req_out_n;
            strobe_n_ff <= nxt_strobe_n;
            wait_ff <= nxt_wait;
        end
    end

    // =========================================================
    // address pin selection
    wire logic [UP_W-1:0] up_mask = ae_mask(ae_ff);
    addr_pin_mux u_mux (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .released_i(released),
        .up_mask_i(up_mask),
        .low_dir_i(low_dir_ff),
        .port_out_i(port_out_ff),
        .port_dir_i(port_dir_ff),
        .addr_i(int_addr_i),
        .pins_o(addr_pins_o)
    );

    // output ports
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign bus_grant_n_o = grant_n_ff;
    assign released_bus_request_out_n_o = req_out_n_ff;
    assign lower_column_strobe_n_o = strobe_n_ff;
    assign wait_hold_o = wait_ff;

    // =========================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking

    property p_ae_enabled_drive;
        disable iff (!rst_n_i)
        (!released && ae_ff == AE_ALL) |=> (addr_pins_o.oe[ADDR_W-1:UP_LSB] == UP_ALL_ONES);
    endproperty
    a_ae_enabled_drive: assert property (p_ae_enabled_drive) else $error("all-ones field not driving");

    property p_ae_zero;
        disable iff (!rst_n_i)
        (ae_ff == AE_RST_ROM && port_dir_ff == '0) |=> (addr_pins_o.oe[ADDR_W-1:UP_LSB] == '0);
    endproperty
    a_ae_zero: assert property (p_ae_zero) else $error("zero field drove an upper line");

    property p_reset_rom;
        (!rst_n_i && !rom_less_i) |=> (ae_ff == AE_RST_ROM);
    endproperty
    a_reset_rom: assert property (p_reset_rom) else $error("rom mode reset value wrong");

    property p_reset_romless;
        (!rst_n_i && rom_less_i) |=> (ae_ff == AE_RST_ROMLESS);
    endproperty
    a_reset_romless: assert property (p_reset_romless) else $error("romless reset value wrong");

    property p_low_dir;
        disable iff (!rst_n_i)
        !released |=> (addr_pins_o.oe[LOW_W-1:0] == $past(low_dir_ff));
    endproperty
    a_low_dir: assert property (p_low_dir) else $error("low line drive not following direction");

    property p_wait_three_state;
        disable iff (!rst_n_i)
        wait_hold_o |-> $past(three_state_i && ext_access_i && !wait_n_i);
    endproperty
    a_wait_three_state: assert property (p_wait_three_state) else $error("wait outside 3-state space");

    property p_release_grant;
        disable iff (!rst_n_i)
        (state_ff == BUS_OWNED && ext_req && !ext_access_i) ##1 (ext_req && !ext_access_i)
            |=> !bus_grant_n_o;
    endproperty
    a_release_grant: assert property (p_release_grant) else $error("request not granted in time");

    property p_grant_complete;
        disable iff (!rst_n_i)
        $fell(bus_grant_n_o) |-> $past(!ext_access_i && state_ff == BUS_RELEASING);
    endproperty
    a_grant_complete: assert property (p_grant_complete) else $error("grant before release done");

    property p_req_out;
        disable iff (!rst_n_i)
        !released_bus_request_out_n_o |-> !bus_grant_n_o && $past(int_ext_req_i);
    endproperty
    a_req_out: assert property (p_req_out) else $error("request out while not released");

    property p_strobe;
        disable iff (!rst_n_i)
        (ctl_ff[CTL_STROBE_EN] && ext_access_i && dram_lower_i && !released)
            |=> !lower_column_strobe_n_o;
    endproperty
    a_strobe: assert property (p_strobe) else $error("lower column strobe missing");

    property p_port_fallback;
        disable iff (!rst_n_i)
        (ae_ff == AE_RST_ROM) |=> (addr_pins_o.oe[ADDR_W-1:UP_LSB] == $past(port_dir_ff));
    endproperty
    a_port_fallback: assert property (p_port_fallback) else $error("disabled line left port");

    c_release: cover property (disable iff (!rst_n_i) $fell(bus_grant_n_o));
    c_req_out: cover property (disable iff (!rst_n_i) $fell(released_bus_request_out_n_o));
    c_wait: cover property (disable iff (!rst_n_i) $rose(wait_hold_o));
    c_write: cover property (disable iff (!rst_n_i) s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// file: design/ext_pin_pkg.sv
// Purpose: shared constants and types for the external bus pin control block
// Assumes: 32-bit AXI4-Lite register access, 24-bit external address bus
// Notes: register offsets are byte addresses, one aligned word each
`default_nettype none
package ext_pin_pkg;
    // =========================================================
    // register map
    localparam logic [7:0] REG_ADDR_CTRL = 8'h00; // address-enable field
    localparam logic [7:0] REG_LOW_DIR = 8'h04; // direction bits of A0..A7
    localparam logic [7:0] REG_PIN_CTRL = 8'h08; // handshake pin enables
    localparam logic [7:0] REG_PORT_OUT = 8'h0C; // port data for unused A8..A23
    localparam logic [7:0] REG_PORT_DIR = 8'h10; // port direction for unused A8..A23
    localparam logic [7:0] REG_STATUS = 8'h14; // read-only state
    // =========================================================
    // field layout
    localparam int AE_W = 4;
    localparam int UP_W = 16; // A8..A23
    localparam int LOW_W = 8; // A0..A7
    localparam int ADDR_W = 24;
    localparam int UP_LSB = 8;
    localparam int CTL_WAIT_EN = 0;
    localparam int CTL_RELEASE_EN = 1;
    localparam int CTL_REQ_OUT_EN = 2;
    localparam int CTL_STROBE_EN = 3;
    localparam int CTL_W = 4;
    localparam int ST_GRANT = 0;
    localparam int ST_REQ_OUT = 1;
    localparam int ST_FSM_LSB = 2;
    // =========================================================
    // reset values
    localparam logic [AE_W-1:0] AE_RST_ROM = 4'h0; // expanded mode with ROM
    localparam logic [AE_W-1:0] AE_RST_ROMLESS = 4'hD; // A8..A20 enabled
    localparam logic [AE_W-1:0] AE_ALL = 4'hF; // A8..A23 enabled
    localparam logic [UP_W-1:0] UP_ALL_ONES = 16'hFFFF;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // =========================================================
    // types
    typedef enum logic [1:0] {
        BUS_OWNED = 2'h0,
        BUS_RELEASING = 2'h1,
        BUS_RELEASED = 2'h3,
        BUS_RECLAIM = 2'h2
    } bus_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] val; // level on each address pin
        logic [ADDR_W-1:0] oe; // high while the pin is driven
    } addr_pins_s;

    // decode of the address-enable field into a mask of A8..A23
    function automatic logic [UP_W-1:0] ae_mask(input logic [AE_W-1:0] n);
        logic [UP_W:0] ones;
        ones = (17'h00001 << n) - 17'h00001;
        if (n == AE_ALL) begin
            ae_mask = UP_ALL_ONES;
        end else begin
            ae_mask = ones[UP_W-1:0];
        end
    endfunction
endpackage
`default_nettype wire

// file: test/ext_bus_pin_control_tb_top.sv
// Purpose: self-checking bench for the external bus pin control block
// Assumes: registers reached over AXI4-Lite, outputs sampled at falling edges
// Notes: random port data and addresses from a fixed seed
`default_nettype none
module ext_bus_pin_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ext_pin_pkg::*;
    // =========================================================
    // signals
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic rom_less = 1'b0, ext_access = 1'b0, three_state = 1'b0, dram_lower = 1'b0;
    logic int_req = 1'b0, want_bus = 1'b0, stall = 1'b0;
    logic [23:0] int_addr = 24'h0;
    logic awready, wready, bvalid, arready, rvalid, wait_hold, wait_n, bus_release_request_in_n;
    logic grant_n, req_out_n, strobe_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    addr_pins_s pins;
    int fails = 0;
    int checks_done = 0;
    int seed = 98;
    always #10 clk_sys_i = ~clk_sys_i;
    // =========================================================
    // design and far side
    ext_bus_pin_control dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rom_less_i(rom_less), .int_addr_i(int_addr),
        .ext_access_i(ext_access), .three_state_i(three_state), .dram_lower_i(dram_lower),
        .int_ext_req_i(int_req), .wait_hold_o(wait_hold), .wait_n_i(wait_n),
        .bus_release_request_in_n_i(bus_release_request_in_n), .bus_grant_n_o(grant_n),
        .released_bus_request_out_n_o(req_out_n), .lower_column_strobe_n_o(strobe_n),
        .addr_pins_o(pins));
    ext_far_model far_u (.clk_sys_i(clk_sys_i), .want_bus_i(want_bus), .stall_i(stall),
        .wait_n_o(wait_n), .bus_release_request_in_n_o(bus_release_request_in_n));
    // =========================================================
    // helpers
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset held three cycles; strap is sampled by the reset edges
    task automatic do_reset(input logic rl);
        @(posedge clk_sys_i);
        rom_less <= rl;
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
    endtask
    // write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_t, w_t, b_t;
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge clk_sys_i);
            aw_t = awready;
            w_t = wready;
            b_t = bvalid;
            resp = bresp;
            @(posedge clk_sys_i);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t === 1'b1) begin
                bready <= 1'b0;
                return;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_t, r_t;
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge clk_sys_i);
            ar_t = arready;
            r_t = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clk_sys_i);
            if (ar_t) arvalid <= 1'b0;
            if (r_t === 1'b1) begin
                rready <= 1'b0;
                return;
            end
        end
    endtask
    task automatic wait_grant(input logic lvl);
        int k;
        k = 0;
        @(negedge clk_sys_i);
        while (grant_n !== lvl && k < 20) begin
            @(negedge clk_sys_i);
            k++;
        end
        check(48'(grant_n), 48'(lvl));
    endtask
    // expected pin levels and drives worked out from the field value
    function automatic addr_pins_s exp_pins(input logic [3:0] n, input logic [7:0] ld,
        input logic [15:0] po, input logic [15:0] pd, input logic [23:0] a, input logic rel);
        addr_pins_s p;
        for (int i = 0; i < 24; i++) begin
            if (i < 8) begin
                p.val[i] = a[i];
                p.oe[i] = ld[i] & ~rel;
            end else if (n == 4'hF || (i - 8) < int'(n)) begin
                p.val[i] = a[i];
                p.oe[i] = ~rel;
            end else begin
                p.val[i] = po[i-8];
                p.oe[i] = pd[i-8];
            end
        end
        return p;
    endfunction
    // =========================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        report_and_stop();
    end
    // =========================================================
    // tests
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] ld;
        logic [15:0] po, pd;
        do_reset(1'b0);
        axi_rd(REG_ADDR_CTRL, d, r);
        check(48'(d), 48'h0);
        settle(0);
        check(pins, exp_pins(4'h0, 8'h00, 16'h0, 16'h0, int_addr, 1'b0));
        do_reset(1'b1);
        axi_rd(REG_ADDR_CTRL, d, r);
        check(48'(d), 48'h00000D);
        settle(0);
        check(pins, exp_pins(4'hD, 8'h00, 16'h0, 16'h0, int_addr, 1'b0));
        $display("test reset values done");
        for (int n = 0; n < 16; n++) begin
            ld = 8'($random(seed));
            po = 16'($random(seed));
            pd = 16'($random(seed));
            axi_wr(REG_ADDR_CTRL, 32'(n), r);
            axi_wr(REG_LOW_DIR, 32'(ld), r);
            axi_wr(REG_PORT_OUT, 32'(po), r);
            axi_wr(REG_PORT_DIR, 32'(pd), r);
            check(48'(r), 48'(AXI_OKAY));
            int_addr <= 24'($random(seed));
            settle(2);
            check(pins, exp_pins(4'(n), ld, po, pd, int_addr, 1'b0));
        end
        axi_rd(8'h18, d, r);
        check(48'(r), 48'(AXI_SLVERR));
        axi_wr(8'h1C, 32'hFFFFFFFF, r);
        check(48'(r), 48'(AXI_SLVERR));
        $display("test address enables done");
        @(posedge clk_sys_i);
        ext_access <= 1'b1;
        want_bus <= 1'b1;
        settle(5);
        check(48'(grant_n), 48'h1);
        axi_wr(REG_PIN_CTRL, 32'h0000000F, r);
        settle(5);
        check(48'(grant_n), 48'h1);
        @(posedge clk_sys_i);
        ext_access <= 1'b0;
        wait_grant(1'b0);
        settle(2);
        check(pins, exp_pins(4'hF, ld, po, pd, int_addr, 1'b1));
        axi_rd(REG_STATUS, d, r);
        check(48'(d), 48'((32'(BUS_RELEASED) << ST_FSM_LSB) | (32'h1 << ST_GRANT)));
        @(posedge clk_sys_i);
        int_req <= 1'b1;
        settle(2);
        check(48'(req_out_n), 48'h0);
        @(posedge clk_sys_i);
        int_req <= 1'b0;
        want_bus <= 1'b0;
        wait_grant(1'b1);
        check(48'(req_out_n), 48'h1);
        $display("test bus release done");
        @(posedge clk_sys_i);
        ext_access <= 1'b1;
        three_state <= 1'b1;
        stall <= 1'b1;
        dram_lower <= 1'b1;
        settle(3);
        check(48'(wait_hold), 48'h1);
        check(48'(strobe_n), 48'h0);
        @(posedge clk_sys_i);
        three_state <= 1'b0;
        dram_lower <= 1'b0;
        settle(3);
        check(48'(wait_hold), 48'h0);
        check(48'(strobe_n), 48'h1);
        $display("test wait and strobe done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: test/ext_far_model.sv
// Purpose: far side of the external bus: another master and a slow device
// Assumes: requests and wait are active low, both lines idle high by pull-up
// Notes: the bench commands when the master wants the bus and when to stall
`default_nettype none
module ext_far_model (
    input wire logic clk_sys_i,
    input wire logic want_bus_i,
    input wire logic stall_i,
    output logic wait_n_o,
    output logic bus_release_request_in_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // registered wishes; the pins idle high like pulled-up lines
    logic want_ff = 1'b0;
    logic stall_ff = 1'b0;
    // request is held for as long as the master wants the bus
    always @(posedge clk_sys_i) begin
        want_ff <= want_bus_i;
        stall_ff <= stall_i;
    end
    assign bus_release_request_in_n_o = ~want_ff;
    assign wait_n_o = ~stall_ff;
endmodule
`default_nettype wire
